// ---- include/rsr_pkg.sv ----
// Package: addresses, fields, counts and carrier types of the reset sequencer
package rsr_pkg;

  // Register byte addresses on the APB (12-bit address space)
  localparam logic [11:0] ADDR_CTRL     = 12'h000; // Reset-on-timeout option
  localparam logic [11:0] ADDR_DBG_CTL  = 12'h004; // Debugger control
  localparam logic [11:0] ADDR_WAKE_EN  = 12'h008; // GPIO recovery enables
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h00c; // Sticky events, write 1 clears
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h010; // Event enables
  localparam logic [11:0] ADDR_STATUS   = 12'h014; // Live sequencer state
  localparam logic [11:0] ADDR_WDT_CTL  = 12'hff0; // Watchdog control and reset cause

  // Field positions
  localparam int CTRL_RTO_BIT = 0; // Reset-on-timeout option
  localparam int DBG_RST_BIT  = 0; // Debugger reset request
  localparam int WCTL_POR_BIT = 7; // Power-on / debugger reset seen
  localparam int WCTL_STP_BIT = 6; // Stop-mode recovery seen
  localparam int WCTL_WDT_BIT = 5; // Watchdog time-out seen
  localparam int WCTL_EXT_BIT = 4; // External pin reset seen
  localparam int IRQ_SYS_BIT  = 0; // System reset completed
  localparam int IRQ_SMR_BIT  = 1; // Stop recovery completed
  localparam int STAT_STOP_BIT = 2; // Stop mode flag in status word

  // Reset values
  localparam logic       CTRL_RTO_RESET = 1'b1;  // Option unprogrammed: reset on time-out
  localparam logic [7:0] WCTL_RESET     = 8'h00; // Cause bits are loaded afterwards
  localparam logic [7:0] WCTL_FLAGS     = 8'hf0; // Bits software may clear
  localparam logic [7:0] WAKE_RESET     = 8'h00;
  localparam logic [1:0] IRQ_RESET      = 2'h0;

  // Sequence lengths
  localparam int WDT_OSC_CYCLES    = 66; // Watchdog oscillator cycles
  localparam int SYS_CLK_CYCLES    = 16; // System clock cycles
  localparam int PIN_FILTER_CYCLES = 4;  // Least low time of the reset pin
  localparam logic [6:0] WDT_LAST = 7'(WDT_OSC_CYCLES - 1);
  localparam logic [4:0] CLK_LAST = 5'(SYS_CLK_CYCLES - 1);
  localparam logic [2:0] PIN_LAST = 3'(PIN_FILTER_CYCLES - 1);

  // Reset vector location in program memory (high byte, low byte follows)
  localparam logic [15:0] VECTOR_ADDR = 16'h0002;

  localparam int GPIO_W = 8;
  localparam int PINS_W = GPIO_W + 6;

  // Sequencer phases, Gray along hold -> osc -> settle -> run
  typedef enum logic [1:0] {
    ST_HOLD   = 2'b00,
    ST_OSC    = 2'b01,
    ST_SETTLE = 2'b11,
    ST_RUN    = 2'b10
  } rsr_phase_t;

  // Asynchronous pins entering the block
  typedef struct packed {
    logic [GPIO_W-1:0] gpio;
    logic              wdt_osc;
    logic              debug_pin;
    logic              reset_pin_n;
    logic              wdt_timeout;
    logic              brownout_detect;
    logic              supply_ok;
  } rsr_pins_t;

  // Recorded cause of the pending sequence
  typedef struct packed {
    logic por;
    logic external_reset_flag;
    logic wdt;
    logic dbg;
  } rsr_cause_t;

  // Whole state of the sequencer
  typedef struct packed {
    rsr_phase_t        st;
    logic              sys;
    rsr_cause_t        cause;
    logic [6:0]        wdt_cnt;
    logic [4:0]        clk_cnt;
    logic [2:0]        pin_cnt;
    logic              stop_mode;
    logic              rto;
    logic              dbg_rst;
    logic [GPIO_W-1:0] wake_en;
    logic [1:0]        irq_stat;
    logic [1:0]        irq_mask;
    logic [7:0]        wdt_ctl;
    logic              cpu_reset_n;
    logic              regs_reset_n;
    logic              dbg_reset_n;
    logic              gpio_force_in;
    logic              sysclk_en;
    logic              osc_en;
    logic              vec_fetch;
    logic              irq;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } rsr_state_t;

endpackage

// ---- rtl/rsr_sync.sv ----
// Two-flop synchroniser with change detection behind the second flop
`timescale 1ns/100ps
module rsr_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] changed
);

  // Three stages: capture, settle, history
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } rsr_sync_t;

  rsr_sync_t q;      // Registered stages
  rsr_sync_t next_q; // Next stages

  // Shift the pins along the chain
  always_comb begin
    next_q    = q;
    next_q.s1 = async_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
  end

  // Stage registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Only settled stages are looked at
  assign level   = q.s2;
  assign changed = q.s2 ^ q.s3;

endmodule

// ---- rtl/rsr_ctrl.sv ----
// Reset and stop-mode recovery sequencer with APB registers
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps

// Functional notes
// - Five sources start a system reset
// - Stop mode: timeout or enabled GPIO recovers
// - Hold 66 oscillator then 16 clock cycles
// - GPIO forced to input during system reset
// - CPU, peripherals idle; oscillators keep running
// - System clock starts after oscillator count
// - System reset reloads defined control values
// - Release fetches vector at 0002h/0003h
// - Power-on or brown-out overrides all sources
// - Debugger reset spares the debugger logic
// - Reset source set depends on mode
// - Supply low holds; then 66-cycle count
// - Then 16-cycle settle; hold until both
// - Power-on sets power-on flag
// - Recovery changes only watchdog control register (here also the IRQ status stop recovery bit)
// - Pin low four cycles; held while low
// - Pin reset sets external reset flag
module rsr_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supply_ok,
  input  wire logic        brownout_detect,
  input  wire logic        wdt_timeout,
  input  wire logic        reset_pin_n,
  input  wire logic        debug_pin,
  input  wire logic        wdt_osc,
  input  wire logic [7:0]  gpio_pins,
  input  wire logic        stop_enter,
  output logic             cpu_reset_n,
  output logic             regs_reset_n,
  output logic             dbg_reset_n,
  output logic             gpio_force_in,
  output logic             sysclk_en,
  output logic             osc_en,
  output logic             vec_fetch,
  output logic [15:0]      vector_addr,
  output logic             irq
);

  rsr_pkg::rsr_state_t q;      // Registered state
  rsr_pkg::rsr_state_t next_q; // Next state
  rsr_pkg::rsr_pins_t  pins;   // Raw pins
  rsr_pkg::rsr_pins_t  s;      // Synchronised pins
  rsr_pkg::rsr_pins_t  chg;    // Synchronised changes

  logic por_req;   // Supply low or brown-out
  logic pin_low;   // Reset pin seen low
  logic pin_req;   // Reset pin low long enough
  logic osc_rise;  // Watchdog oscillator edge
  logic wdt_rise;  // Watchdog time-out event
  logic wake_gpio; // Enabled GPIO transition
  logic sys_req;   // Any system reset request
  logic smr_req;   // Any recovery request
  logic access;    // APB access phase, first cycle
  logic wr;        // APB write taking effect

  // Gather pins into one carrier
  assign pins = '{gpio: gpio_pins, wdt_osc: wdt_osc, debug_pin: debug_pin,
                  reset_pin_n: reset_pin_n, wdt_timeout: wdt_timeout,
                  brownout_detect: brownout_detect, supply_ok: supply_ok};

  // Every pin crosses two flops first
  rsr_sync #(.W(rsr_pkg::PINS_W)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pins),
    .level    (s),
    .changed  (chg)
  );

  // Request decoding
  always_comb begin
    por_req   = !s.supply_ok || s.brownout_detect;
    pin_low   = !s.reset_pin_n;
    pin_req   = pin_low && (q.pin_cnt == rsr_pkg::PIN_LAST);
    osc_rise  = chg.wdt_osc && s.wdt_osc;
    wdt_rise  = chg.wdt_timeout && s.wdt_timeout;
    wake_gpio = |(chg.gpio & q.wake_en);
    // Normal/halt sources vs stop sources
    if (q.stop_mode) begin
      sys_req = por_req || pin_req || !s.debug_pin;
      smr_req = wdt_rise || wake_gpio;
    end else begin
      sys_req = por_req || pin_req || (wdt_rise && q.rto) || q.dbg_rst;
      smr_req = 1'b0;
    end
    access = psel && penable && !q.pready;
    wr     = access && pwrite;
  end

  // Enter a system reset with the given cause
  function automatic rsr_pkg::rsr_state_t start_sys(input rsr_pkg::rsr_state_t x,
                                                     input rsr_pkg::rsr_cause_t c);
    rsr_pkg::rsr_state_t y;
    y           = x;
    y.st        = rsr_pkg::ST_HOLD;
    y.sys       = 1'b1;
    y.cause     = c;
    y.wdt_cnt   = '0;
    y.clk_cnt   = '0;
    y.stop_mode = 1'b0;
    y.rto       = rsr_pkg::CTRL_RTO_RESET;
    y.dbg_rst   = 1'b0;
    y.wake_en   = rsr_pkg::WAKE_RESET;
    return y;
  endfunction

  // Next-state logic: bus, sequencer, outputs
  always_comb begin
    rsr_pkg::rsr_cause_t c;
    c                = '0;
    next_q           = q;
    next_q.pready    = 1'b0;
    next_q.pslverr   = 1'b0;
    next_q.vec_fetch = 1'b0;

    // Reset pin low-time filter
    if (pin_low) begin
      if (q.pin_cnt != rsr_pkg::PIN_LAST) begin
        next_q.pin_cnt = q.pin_cnt + 3'h1;
      end
    end else begin
      next_q.pin_cnt = '0;
    end

    // APB slave: answer one cycle into the access phase
    if (access) begin
      next_q.pready = 1'b1;
      next_q.prdata = '0;
      case (paddr)
        rsr_pkg::ADDR_CTRL: begin
          next_q.prdata[rsr_pkg::CTRL_RTO_BIT] = q.rto;
          if (wr) next_q.rto = pwdata[rsr_pkg::CTRL_RTO_BIT];
        end
        rsr_pkg::ADDR_DBG_CTL: begin
          next_q.prdata[rsr_pkg::DBG_RST_BIT] = q.dbg_rst;
          if (wr) next_q.dbg_rst = pwdata[rsr_pkg::DBG_RST_BIT];
        end
        rsr_pkg::ADDR_WAKE_EN: begin
          next_q.prdata[7:0] = q.wake_en;
          if (wr) next_q.wake_en = pwdata[7:0];
        end
        rsr_pkg::ADDR_IRQ_STAT: begin
          next_q.prdata[1:0] = q.irq_stat;
          if (wr) next_q.irq_stat = q.irq_stat & ~pwdata[1:0];
        end
        rsr_pkg::ADDR_IRQ_MASK: begin
          next_q.prdata[1:0] = q.irq_mask;
          if (wr) next_q.irq_mask = pwdata[1:0];
        end
        rsr_pkg::ADDR_STATUS: begin
          next_q.prdata[1:0] = q.st;
          next_q.prdata[rsr_pkg::STAT_STOP_BIT] = q.stop_mode;
        end
        rsr_pkg::ADDR_WDT_CTL: begin
          next_q.prdata[7:0] = q.wdt_ctl;
          if (wr) next_q.wdt_ctl = q.wdt_ctl & ~(pwdata[7:0] & rsr_pkg::WCTL_FLAGS);
        end
        default: begin
          next_q.pslverr = 1'b1; // Unmapped address
        end
      endcase
    end

    // Sequencer; runs after the bus so hardware sets win over clears
    case (q.st)
      rsr_pkg::ST_RUN: begin
        if (sys_req) begin
          // Priority: supply, pin, watchdog, debugger
          if (por_req) c.por = 1'b1;
          else if (pin_req) c.external_reset_flag = 1'b1;
          else if (wdt_rise && q.rto && !q.stop_mode) c.wdt = 1'b1;
          else if (q.dbg_rst) c.dbg = 1'b1;
          else c.por = 1'b1;                                  // Debug pin in stop
          next_q = start_sys(next_q, c);
        end else if (smr_req) begin
          next_q.st        = rsr_pkg::ST_HOLD;
          next_q.sys       = 1'b0;
          next_q.cause     = '0;
          next_q.cause.wdt = wdt_rise;
          next_q.wdt_cnt   = '0;
          next_q.clk_cnt   = '0;
        end else if (stop_enter && !q.stop_mode) begin
          next_q.stop_mode = 1'b1;
        end
      end
      rsr_pkg::ST_HOLD: begin
        // Supply low or pin low keeps the sequence parked
        if (por_req && !q.cause.por) begin
          c.por  = 1'b1;
          next_q = start_sys(next_q, c);
        end else if (!por_req && !pin_low) begin
          next_q.st      = rsr_pkg::ST_OSC;
          next_q.wdt_cnt = '0;
        end
      end
      rsr_pkg::ST_OSC, rsr_pkg::ST_SETTLE: begin
        if (por_req) begin
          c.por  = 1'b1;
          next_q = start_sys(next_q, c);
        end else if (pin_req) begin
          c      = q.cause;
          c.external_reset_flag  = 1'b1;
          next_q = start_sys(next_q, c);
        end else if (q.st == rsr_pkg::ST_OSC) begin
          if (osc_rise) begin
            if (q.wdt_cnt == rsr_pkg::WDT_LAST) begin
              next_q.st      = rsr_pkg::ST_SETTLE;
              next_q.clk_cnt = '0;
            end else begin
              next_q.wdt_cnt = q.wdt_cnt + 7'h01;
            end
          end
        end else if (q.clk_cnt == rsr_pkg::CLK_LAST) begin
          next_q.st        = rsr_pkg::ST_RUN;
          next_q.vec_fetch = 1'b1;
          next_q.stop_mode = 1'b0;
          if (q.sys) begin
            next_q.wdt_ctl = rsr_pkg::WCTL_RESET;
            next_q.wdt_ctl[rsr_pkg::WCTL_POR_BIT] = q.cause.por || q.cause.dbg;
            next_q.wdt_ctl[rsr_pkg::WCTL_EXT_BIT] = q.cause.external_reset_flag;
            next_q.wdt_ctl[rsr_pkg::WCTL_WDT_BIT] = q.cause.wdt;
            next_q.irq_stat[rsr_pkg::IRQ_SYS_BIT] = 1'b1;
          end else begin
            next_q.wdt_ctl = rsr_pkg::WCTL_RESET;
            next_q.wdt_ctl[rsr_pkg::WCTL_STP_BIT] = 1'b1;
            next_q.wdt_ctl[rsr_pkg::WCTL_WDT_BIT] = q.cause.wdt;
            next_q.irq_stat[rsr_pkg::IRQ_SMR_BIT] = 1'b1;
          end
        end else begin
          next_q.clk_cnt = q.clk_cnt + 5'h01;
        end
      end
      default: begin
        next_q.st = rsr_pkg::ST_HOLD;
      end
    endcase

    // Outputs follow the next phase so they leave flops in step with it
    next_q.cpu_reset_n   = (next_q.st == rsr_pkg::ST_RUN);
    next_q.regs_reset_n  = next_q.cpu_reset_n || !next_q.sys;
    next_q.dbg_reset_n   = next_q.regs_reset_n || next_q.cause.dbg;
    next_q.gpio_force_in = !next_q.regs_reset_n;
    next_q.sysclk_en     = (next_q.st == rsr_pkg::ST_SETTLE) ||
                           (next_q.cpu_reset_n && !next_q.stop_mode);
    next_q.osc_en        = !(next_q.cpu_reset_n && next_q.stop_mode);
    next_q.irq           = |(next_q.irq_stat & next_q.irq_mask);
  end

  // State register; power-on starts held in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q               <= '0;
      q.st            <= rsr_pkg::ST_HOLD;
      q.sys           <= 1'b1;
      q.cause.por     <= 1'b1;
      q.rto           <= rsr_pkg::CTRL_RTO_RESET;
      q.wdt_ctl       <= rsr_pkg::WCTL_RESET;
      q.gpio_force_in <= 1'b1;
      q.osc_en        <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // Port drive
  assign prdata        = q.prdata;
  assign pready        = q.pready;
  assign pslverr       = q.pslverr;
  assign cpu_reset_n   = q.cpu_reset_n;
  assign regs_reset_n  = q.regs_reset_n;
  assign dbg_reset_n   = q.dbg_reset_n;
  assign gpio_force_in = q.gpio_force_in;
  assign sysclk_en     = q.sysclk_en;
  assign osc_en        = q.osc_en;
  assign vec_fetch     = q.vec_fetch;
  assign vector_addr   = rsr_pkg::VECTOR_ADDR;
  assign irq           = q.irq;

  // Checks on the sequencer
  property p_osc_len;
    @(posedge pclk) disable iff (!presetn)
    (q.st == rsr_pkg::ST_OSC && next_q.st == rsr_pkg::ST_SETTLE) |-> q.wdt_cnt == rsr_pkg::WDT_LAST && osc_rise;
  endproperty
  a_osc_len: assert property (p_osc_len) else $error("Oscillator count not 66");
  property p_settle_len;
    @(posedge pclk) disable iff (!presetn)
    $rose(q.st == rsr_pkg::ST_SETTLE) |-> (q.st == rsr_pkg::ST_SETTLE && !por_req && !pin_req)[*8]
      ##9 (q.st == rsr_pkg::ST_RUN || por_req || pin_req);
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("Settle phase not 16 cycles");
  property p_gpio_in;
    @(posedge pclk) disable iff (!presetn)
    (q.st != rsr_pkg::ST_RUN && q.sys) |-> gpio_force_in && !regs_reset_n;
  endproperty
  a_gpio_in: assert property (p_gpio_in) else $error("GPIO not forced during reset");
  property p_cpu_idle;
    @(posedge pclk) disable iff (!presetn)
    (q.st != rsr_pkg::ST_RUN) |-> !cpu_reset_n && osc_en;
  endproperty
  a_cpu_idle: assert property (p_cpu_idle) else $error("CPU released or oscillator off");
  property p_clk_late;
    @(posedge pclk) disable iff (!presetn)
    (q.st == rsr_pkg::ST_OSC || q.st == rsr_pkg::ST_HOLD) |-> !sysclk_en;
  endproperty
  a_clk_late: assert property (p_clk_late) else $error("System clock started early");
  property p_por_wins;
    @(posedge pclk) disable iff (!presetn)
    (por_req && q.st != rsr_pkg::ST_HOLD) |=> q.st == rsr_pkg::ST_HOLD && q.cause.por && q.sys;
  endproperty
  a_por_wins: assert property (p_por_wins) else $error("Supply request lost priority");
  property p_pin_reset;
    @(posedge pclk) disable iff (!presetn)
    (pin_req && q.st == rsr_pkg::ST_RUN) |=> q.st == rsr_pkg::ST_HOLD ##1 !cpu_reset_n;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("Pin reset not taken");
  property p_flags;
    @(posedge pclk) disable iff (!presetn)
    $rose(q.st == rsr_pkg::ST_RUN) |-> vec_fetch && cpu_reset_n &&
      q.wdt_ctl[rsr_pkg::WCTL_EXT_BIT] == $past(q.cause.external_reset_flag && q.sys) &&
      q.wdt_ctl[rsr_pkg::WCTL_POR_BIT] == $past(q.sys && (q.cause.por || q.cause.dbg));
  endproperty
  a_flags: assert property (p_flags) else $error("Cause flags or vector fetch wrong");
  property p_dbg_spared;
    @(posedge pclk) disable iff (!presetn)
    ((q.dbg_rst && q.st == rsr_pkg::ST_RUN && !sys_req) ||
     (q.cause.dbg && q.st != rsr_pkg::ST_RUN)) |-> dbg_reset_n;
  endproperty
  a_dbg_spared: assert property (p_dbg_spared) else $error("Debugger logic was reset");
  property p_smr_keep;
    @(posedge pclk) disable iff (!presetn)
    (q.stop_mode && q.st == rsr_pkg::ST_RUN && smr_req && !sys_req) |=>
      !q.sys ##1 (regs_reset_n && !cpu_reset_n);
  endproperty
  a_smr_keep: assert property (p_smr_keep) else $error("Recovery disturbed registers");
  c_sys_done: cover property (@(posedge pclk) disable iff (!presetn) q.sys && $rose(cpu_reset_n));
  c_smr_done: cover property (@(posedge pclk) disable iff (!presetn) !q.sys && $rose(cpu_reset_n));
  c_restart: cover property (@(posedge pclk) disable iff (!presetn) q.st == rsr_pkg::ST_OSC && por_req);
  c_ext: cover property (@(posedge pclk) disable iff (!presetn) $rose(q.wdt_ctl[rsr_pkg::WCTL_EXT_BIT]));

endmodule

// ---- bench/rsr_cpu_model.sv ----
// CPU and peripheral stand-in that watches the reset outputs
`timescale 1ns/100ps
module rsr_cpu_model (
  input  wire logic        pclk,
  input  wire logic        cpu_reset_n,
  input  wire logic        regs_reset_n,
  input  wire logic        dbg_reset_n,
  input  wire logic        gpio_force_in,
  input  wire logic        sysclk_en,
  input  wire logic        vec_fetch,
  input  wire logic [15:0] vector_addr,
  input  wire logic        clr,
  output logic      [7:0]  settle_cnt,
  output logic      [2:0]  seen,
  output logic      [15:0] pc
);
  // Record what happened while held; the release loads the vector location
  always_ff @(posedge pclk) begin
    if (clr) begin
      settle_cnt <= 8'h00;
      seen       <= 3'h0;
      pc         <= 16'hffff;
    end else begin
      if (!cpu_reset_n && sysclk_en) begin
        settle_cnt <= settle_cnt + 8'h01;
      end
      if (!cpu_reset_n) begin
        seen <= seen | {gpio_force_in, ~regs_reset_n, ~dbg_reset_n};
      end
      if (vec_fetch) begin
        pc <= vector_addr;
      end
    end
  end
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the reset and stop recovery sequencer
`timescale 1ns/100ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, clr, err_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        supply_ok, brownout_detect, wdt_timeout, reset_pin_n, debug_pin, stop_enter;
  logic [7:0]  gpio_pins, settle_cnt;
  logic [2:0]  div = 3'h0;
  logic [2:0]  seen;
  logic        cpu_reset_n, regs_reset_n, dbg_reset_n, gpio_force_in, sysclk_en, osc_en, vec_fetch, irq;
  logic [15:0] vector_addr, pc;
  int          n_errors, samples_checked;

  rsr_ctrl rsr_ctrl_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_ok(supply_ok), .brownout_detect(brownout_detect), .wdt_timeout(wdt_timeout),
    .reset_pin_n(reset_pin_n), .debug_pin(debug_pin), .wdt_osc(div[2]), .gpio_pins(gpio_pins),
    .stop_enter(stop_enter), .cpu_reset_n(cpu_reset_n), .regs_reset_n(regs_reset_n),
    .dbg_reset_n(dbg_reset_n), .gpio_force_in(gpio_force_in), .sysclk_en(sysclk_en), .osc_en(osc_en),
    .vec_fetch(vec_fetch), .vector_addr(vector_addr), .irq(irq));
  rsr_cpu_model rsr_cpu_model_i (.pclk(pclk), .cpu_reset_n(cpu_reset_n), .regs_reset_n(regs_reset_n),
    .dbg_reset_n(dbg_reset_n), .gpio_force_in(gpio_force_in), .sysclk_en(sysclk_en),
    .vec_fetch(vec_fetch), .vector_addr(vector_addr), .clr(clr), .settle_cnt(settle_cnt),
    .seen(seen), .pc(pc));

  // Clock source
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Watchdog oscillator at one eighth of the clock
  always @(posedge pclk) begin
    div <= div + 3'h1;
  end

  // Verdict and end of run
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Single comparison point
  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    samples_checked++;
    if (seen_v !== exp_v) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask

  // One APB transfer; answer taken at the edge that samples pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_errors++;
      end_sim();
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wait for a hold and release, then check what the CPU side saw
  task automatic wait_rel(input logic [2:0] exp_seen, input logic [31:0] exp_ctl, input string name);
    int k;
    for (k = 0; k < 3000 && cpu_reset_n !== 1'b0; k++) @(negedge pclk);
    if (k == 3000) begin
      n_errors++;
      end_sim();
    end
    for (k = 0; k < 3000 && cpu_reset_n !== 1'b1; k++) @(negedge pclk);
    if (k == 3000) begin
      n_errors++;
      end_sim();
    end
    @(negedge pclk);
    check(settle_cnt, 8'h10);
    check(pc, 16'h0002);
    check(seen, exp_seen);
    apb(1'b0, rsr_pkg::ADDR_WDT_CTL, 32'h0);
    check(rd, exp_ctl);
    apb(1'b1, rsr_pkg::ADDR_WDT_CTL, 32'hf0);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    $display("test %s done", name);
  endtask

  // Pulse or hold a level for some cycles
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, stop_enter, wdt_timeout, brownout_detect} = '0;
    {supply_ok, reset_pin_n, debug_pin, clr} = 4'hf;
    gpio_pins = 8'h00;
    n_errors = 0;
    samples_checked = 0;
    hold(6);
    presetn <= 1'b1;
    clr <= 1'b0;
    wait_rel(3'b111, 32'h80, "power_on");
    apb(1'b0, rsr_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    check(err_seen, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, rsr_pkg::ADDR_IRQ_MASK, 32'h1);
    check(irq, 1'b1);
    apb(1'b1, rsr_pkg::ADDR_IRQ_STAT, 32'h3);
    check(irq, 1'b0);
    reset_pin_n <= 1'b0;
    hold(3);
    reset_pin_n <= 1'b1;
    hold(10);
    check(cpu_reset_n, 1'b1);
    apb(1'b1, rsr_pkg::ADDR_CTRL, 32'h0);
    reset_pin_n <= 1'b0;
    hold(12);
    reset_pin_n <= 1'b1;
    wait_rel(3'b111, 32'h10, "pin");
    apb(1'b0, rsr_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, rsr_pkg::ADDR_CTRL, 32'h0);
    wdt_timeout <= 1'b1;
    hold(4);
    wdt_timeout <= 1'b0;
    hold(10);
    check(cpu_reset_n, 1'b1);
    apb(1'b1, rsr_pkg::ADDR_CTRL, 32'h1);
    wdt_timeout <= 1'b1;
    hold(4);
    wdt_timeout <= 1'b0;
    wait_rel(3'b111, 32'h20, "watchdog");
    apb(1'b1, rsr_pkg::ADDR_DBG_CTL, 32'h1);
    wait_rel(3'b110, 32'h80, "debugger");
    apb(1'b0, rsr_pkg::ADDR_DBG_CTL, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, rsr_pkg::ADDR_WAKE_EN, 32'h1);
    stop_enter <= 1'b1;
    hold(1);
    stop_enter <= 1'b0;
    apb(1'b0, rsr_pkg::ADDR_STATUS, 32'h0);
    check(rd[rsr_pkg::STAT_STOP_BIT], 1'b1);
    check(osc_en, 1'b0);
    gpio_pins <= 8'h01;
    wait_rel(3'b000, 32'h40, "stop_recovery");
    apb(1'b0, rsr_pkg::ADDR_WAKE_EN, 32'h0);
    check(rd, 32'h1);
    brownout_detect <= 1'b1;
    hold(8);
    brownout_detect <= 1'b0;
    wait_rel(3'b111, 32'h80, "brownout");
    // Watchdog time-out in stop mode recovers and records both bits
    stop_enter <= 1'b1;
    hold(1);
    stop_enter <= 1'b0;
    wdt_timeout <= 1'b1;
    hold(4);
    wdt_timeout <= 1'b0;
    wait_rel(3'b000, 32'h60, "stop_watchdog");
    // Debug pin low in stop mode forces a full system reset
    stop_enter <= 1'b1;
    hold(1);
    stop_enter <= 1'b0;
    debug_pin <= 1'b0;
    hold(4);
    debug_pin <= 1'b1;
    wait_rel(3'b111, 32'h80, "stop_debug_pin");
    end_sim();
  end
endmodule
